/* rtl/ipr_defines.vh */
// Purpose: Shared constants for the interrupt priority resolver
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Control register indices are printed offsets; byte address is index times four
`ifndef IPR_DEFINES_VH
`define IPR_DEFINES_VH

// Register map (byte addresses and indices)
`define IPR_CTRL_IDX_FIRST  12'h070
`define IPR_CTRL_IDX_LAST   12'h07f
`define IPR_PS_ADDR         12'h200
`define IPR_PMR_ADDR        12'h204
`define IPR_WIN_ADDR        12'h208

// Control register fields
`define IPR_LVL_LSB         0
`define IPR_LVL_MSB         2
`define IPR_REQ_BIT         3

// Processor status fields
`define IPR_PS_IFLAG_BIT    2
`define IPR_PS_THR_LSB      8
`define IPR_PS_THR_MSB      10

// Processor mode register detection select field
`define IPR_PMR_DET_LSB     4
`define IPR_PMR_DET_MSB     5
`define IPR_PMR_RESET       8'h00

// Detection durations in processor clocks
`define IPR_DET_SEL_SEVEN   2'b00
`define IPR_DET_SEL_FOUR    2'b01
`define IPR_DET_CYC_SEVEN   3'h7
`define IPR_DET_CYC_FOUR    3'h4
`define IPR_DET_CYC_TWO     3'h2

// Threshold values loaded on entry
`define IPR_THR_RESET       3'h0
`define IPR_THR_WATCHDOG    3'h7

// Acknowledge sequence timing (cycles counted from its first cycle)
`define IPR_ACK_CYCLES      5'd13
`define IPR_ACK_PUSHES      3'd5
`define IPR_RTI_POPS        3'd5

// Source indices presented to the sequencer
`define IPR_SRC_WATCHDOG    5'd16
`define IPR_SRC_BREAK       5'd17
`define IPR_SRC_DIVZERO     5'd18
`define IPR_PG_VECTOR       8'h00

`endif

/* rtl/ipr_resolver.v */
// Purpose: Interrupt priority resolution, acknowledge stacking and return restore
// Assumes: Sequencer strobes are synchronous to clk; stack memory lives in the core
// Notes:   Sixteen maskable sources resolved in a fixed chain; traps and watchdog fixed
//
// How it works
// RULE1 - Accept only highest priority among sampled requests
// RULE2 - Maskable levels programmable, watchdog and reset fixed
// RULE3 - Chain compares each level with running winner
// RULE4 - Unrequested sources pass winner unchanged
// RULE5 - Equal levels keep earlier chain entry
// RULE6 - Accept when level above threshold, flag clear
// RULE7 - Sampling pulse comes from opcode fetch
// RULE8 - Requests and levels latched until detection ends
// RULE9 - No new sampling pulse while detecting
// RULE10 - Mode bits 4,5 select two, four, seven
// RULE11 - Reset gives select 00, seven cycles
// RULE12 - Detect per instruction and during acknowledge
// RULE13 - Acknowledge starts after current instruction completes
// RULE14 - Push bank, counter high, low, status high, low
// RULE15 - Set disable flag, clear request, load threshold
// RULE16 - Bank zero, counter from source vector
// RULE17 - Threshold zero reset, seven watchdog, traps unchanged
// RULE18 - Losing and other requests stay set
// RULE19 - Watchdog and traps taken regardless of mask
// RULE20 - Return restores status, counter, bank reversed
// RULE21 - Acknowledge takes at least thirteen cycles
// RULE22 - Service code clears unwanted requests before return
// RULE23 - Control register: level bits 0-2, request bit 3
// RULE24 - Disable flag bit 2, set by reset
// RULE25 - Threshold bits 8-10, seven blocks all
// RULE26 - Winner index and strobe at detection end
`timescale 1ns/1ps
`include "ipr_defines.vh"

module ipr_resolver #(
  parameter NSRC = 16                       // Maskable sources in the chain
) (
  input  wire        clk,                   // Processor clock, 20 MHz
  input  wire        reset,                 // Synchronous reset, active high
  input  wire        psel,                  // APB select
  input  wire        penable,               // APB access phase
  input  wire        pwrite,                // APB write
  input  wire [11:0] paddr,                 // APB byte address
  input  wire [31:0] pwdata,                // APB write data
  output reg  [31:0] prdata_q,              // APB read data
  output reg         pready_q,              // APB ready
  output reg         pslverr_q,             // APB error for unmapped address
  input  wire [NSRC-1:0] src_event,         // Request pulses in chain order
  input  wire        wdt_event,             // Watchdog request pulse
  input  wire        brk_trap_instr,        // Break trap pulse
  input  wire        div_zero_trap,         // Divide-by-zero trap pulse
  input  wire        opcode_fetch,          // First half of opcode fetch cycle
  input  wire        instr_done,            // Last cycle of current instruction
  input  wire        return_from_irq_instr, // Start of return sequence
  input  wire [7:0]  program_bank,          // Current bank
  input  wire [15:0] program_counter,       // Address of next instruction
  input  wire [15:0] status_other,          // Status bits not held here
  input  wire [7:0]  stack_rd_data,         // Byte popped, valid with stack_pop_q
  output reg         stack_push_q,          // Push strobe
  output reg  [7:0]  stack_wr_data_q,       // Byte to push
  output reg         stack_pop_q,           // Pop strobe
  output reg         ack_busy_q,            // Acknowledge or return running
  output reg         win_valid_q,           // Detection finished with acceptance
  output reg  [4:0]  win_idx_q,             // Winning source index
  output reg         vector_load_q,         // Load counter from vector
  output reg  [4:0]  vector_idx_q,          // Vector of accepted source
  output reg  [7:0]  bank_out_q,            // Bank to load with vector or restore
  output reg         restore_valid_q,       // Return restore done
  output reg  [15:0] restore_pc_q,          // Restored counter
  output reg  [15:0] restore_ps_q,          // Restored status
  output reg         iflag_q,               // Global disable flag
  output reg  [2:0]  cpu_priority_threshold_q // Processor threshold
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ACK  = 2'd1;
  localparam ST_RTI  = 2'd2;

  // Maps a printed control register index to its chain position
  function [3:0] ctrl_to_src;
    input [3:0] low;
    begin
      case (low)
        4'h0:    ctrl_to_src = 4'd15;
        4'h1:    ctrl_to_src = 4'd12;
        4'h2:    ctrl_to_src = 4'd11;
        4'h3:    ctrl_to_src = 4'd14;
        4'h4:    ctrl_to_src = 4'd13;
        4'hd:    ctrl_to_src = 4'd0;
        4'he:    ctrl_to_src = 4'd1;
        4'hf:    ctrl_to_src = 4'd2;
        default: ctrl_to_src = low - 4'd2;
      endcase
    end
  endfunction

  reg [2:0]      level_q [0:NSRC-1];
  reg [NSRC-1:0] req_q;
  reg [7:0]      pmr_q;
  reg            wdt_pend_q;
  reg            brk_pend_q;
  reg            div_pend_q;
  reg [2:0]      lat_level_q [0:NSRC-1];
  reg [NSRC-1:0] lat_req_q;
  reg            lat_wdt_q;
  reg            lat_brk_q;
  reg            lat_div_q;
  reg            det_busy_q;
  reg [2:0]      det_cnt_q;
  reg            acc_pend_q;
  reg [4:0]      acc_src_q;
  reg [2:0]      acc_lvl_q;
  reg [1:0]      state_q;
  reg [4:0]      seq_cnt_q;
  reg [39:0]     push_bytes_q;
  reg [39:0]     pop_bytes_q;

  wire        setup    = psel & ~penable;
  wire        acc_wr   = psel & penable & pready_q & pwrite;
  wire [11:0] idx      = {2'b00, paddr[11:2]};
  wire        hit_ctrl = (idx >= `IPR_CTRL_IDX_FIRST) && (idx <= `IPR_CTRL_IDX_LAST) && (paddr[1:0] == 2'b00);
  wire [3:0]  ctrl_src = ctrl_to_src(idx[3:0]);
  wire        hit_ps   = (paddr == `IPR_PS_ADDR);
  wire        hit_pmr  = (paddr == `IPR_PMR_ADDR);
  wire        hit_win  = (paddr == `IPR_WIN_ADDR);

  wire [15:0] status_now = {status_other[15:11], cpu_priority_threshold_q, status_other[7:3],
                            iflag_q, status_other[1:0]};

  // Fixed chain from the top index down; strict greater keeps the earlier entry on ties
  reg [2:0] chain_lvl;
  reg [3:0] chain_src;
  reg       chain_any;
  integer   i;
  always @* begin
    chain_lvl = 3'h0;                                         // see RULE3
    chain_src = 4'h0;
    chain_any = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (lat_req_q[i] && (lat_level_q[i] > chain_lvl)) begin // see RULE4, see RULE5
        chain_lvl = lat_level_q[i];                           // see RULE3
        chain_src = i[3:0];
        chain_any = 1'b1;
      end
    end
  end

  // Level 0 never wins the chain, and threshold 7 blocks every maskable source
  wire mask_ok  = chain_any && (chain_lvl > cpu_priority_threshold_q) && !iflag_q; // see RULE6, see RULE25
  wire det_end  = det_busy_q && (det_cnt_q == 3'h0);
  wire nm_any   = lat_div_q | lat_brk_q | lat_wdt_q;          // see RULE19
  wire ack_go   = acc_pend_q && instr_done && (state_q == ST_IDLE); // see RULE13
  wire rti_go   = return_from_irq_instr && (state_q == ST_IDLE) && !ack_go;
  wire samp     = (opcode_fetch || ack_go) && !det_busy_q;  // see RULE7, see RULE9, see RULE12
  wire ack_mark = (state_q == ST_ACK) && (seq_cnt_q == 5'd6);
  wire ack_end  = (state_q == ST_ACK) && (seq_cnt_q == `IPR_ACK_CYCLES - 5'd1);
  wire rti_end  = (state_q == ST_RTI) && (seq_cnt_q == {2'b00, `IPR_RTI_POPS} - 5'd1);

  reg [2:0] det_len;
  always @* begin
    case (pmr_q[`IPR_PMR_DET_MSB:`IPR_PMR_DET_LSB])          // see RULE10
      `IPR_DET_SEL_SEVEN: det_len = `IPR_DET_CYC_SEVEN;
      `IPR_DET_SEL_FOUR:  det_len = `IPR_DET_CYC_FOUR;
      default:            det_len = `IPR_DET_CYC_TWO;
    endcase
  end

  // Per-source control: event sets win over any clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      wire sw_hit = acc_wr && hit_ctrl && (ctrl_src == g);
      always @(posedge clk) begin
        if (reset) begin
          level_q[g] <= 3'h0;
          req_q[g]   <= 1'b0;
        end else begin
          if (sw_hit)
            level_q[g] <= pwdata[`IPR_LVL_MSB:`IPR_LVL_LSB]; // see RULE2, see RULE23
          if (src_event[g])
            req_q[g] <= 1'b1;                                 // see RULE23
          else if (sw_hit)
            req_q[g] <= pwdata[`IPR_REQ_BIT];
          else if (ack_mark && acc_src_q == g)
            req_q[g] <= 1'b0;                                 // see RULE15, see RULE18
        end
      end
      always @(posedge clk) begin
        if (reset) begin
          lat_level_q[g] <= 3'h0;
          lat_req_q[g]   <= 1'b0;
        end else if (samp) begin
          lat_level_q[g] <= level_q[g];                       // see RULE8
          lat_req_q[g]   <= req_q[g];
        end
      end
    end
  endgenerate

  // Detection timer and acceptance, none mid-acknowledge
  always @(posedge clk) begin
    if (reset) begin
      det_busy_q  <= 1'b0;
      det_cnt_q   <= 3'h0;
      lat_wdt_q   <= 1'b0;
      lat_brk_q   <= 1'b0;
      lat_div_q   <= 1'b0;
      acc_pend_q  <= 1'b0;
      acc_src_q   <= 5'd0;
      acc_lvl_q   <= 3'h0;
      win_valid_q <= 1'b0;
      win_idx_q   <= 5'd0;
    end else begin
      win_valid_q <= 1'b0;
      if (samp) begin
        det_busy_q <= 1'b1;
        det_cnt_q  <= det_len - 3'h2;                         // see RULE10, see RULE8
        lat_wdt_q  <= wdt_pend_q;
        lat_brk_q  <= brk_pend_q;
        lat_div_q  <= div_pend_q;
      end else if (det_end) begin
        det_busy_q <= 1'b0;                                   // see RULE12
      end else if (det_busy_q) begin
        det_cnt_q <= det_cnt_q - 3'h1;
      end
      if (ack_go)
        acc_pend_q <= 1'b0;
      else if (det_end && !acc_pend_q && state_q != ST_ACK && (nm_any || mask_ok)) begin
        acc_pend_q  <= 1'b1;                                  // see RULE1
        win_valid_q <= 1'b1;                                  // see RULE26
        acc_lvl_q   <= chain_lvl;
        if (lat_div_q) begin
          acc_src_q <= `IPR_SRC_DIVZERO;
          win_idx_q <= `IPR_SRC_DIVZERO;
        end else if (lat_brk_q) begin
          acc_src_q <= `IPR_SRC_BREAK;
          win_idx_q <= `IPR_SRC_BREAK;
        end else if (lat_wdt_q) begin
          acc_src_q <= `IPR_SRC_WATCHDOG;                     // see RULE19
          win_idx_q <= `IPR_SRC_WATCHDOG;
        end else begin
          acc_src_q <= {1'b0, chain_src};
          win_idx_q <= {1'b0, chain_src};
        end
      end
    end
  end

  // Fixed-priority sources; a new event keeps the pending flag set over a clear in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      wdt_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      div_pend_q <= 1'b0;
    end else begin
      wdt_pend_q <= wdt_event     | (wdt_pend_q & ~(ack_mark && acc_src_q == `IPR_SRC_WATCHDOG));
      brk_pend_q <= brk_trap_instr | (brk_pend_q & ~(ack_mark && acc_src_q == `IPR_SRC_BREAK));
      div_pend_q <= div_zero_trap  | (div_pend_q & ~(ack_mark && acc_src_q == `IPR_SRC_DIVZERO));
    end
  end

  // Acknowledge and return sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_q         <= ST_IDLE;
      seq_cnt_q       <= 5'd0;
      push_bytes_q    <= 40'h0;
      pop_bytes_q     <= 40'h0;
      stack_push_q    <= 1'b0;
      stack_wr_data_q <= 8'h00;
      stack_pop_q     <= 1'b0;
      ack_busy_q      <= 1'b0;
      vector_load_q   <= 1'b0;
      vector_idx_q    <= 5'd0;
      bank_out_q      <= 8'h00;
      restore_valid_q <= 1'b0;
      restore_pc_q    <= 16'h0000;
      restore_ps_q    <= 16'h0000;
    end else begin
      stack_push_q    <= 1'b0;
      stack_pop_q     <= 1'b0;
      vector_load_q   <= 1'b0;
      restore_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          seq_cnt_q <= 5'd0;
          if (ack_go) begin
            state_q      <= ST_ACK;
            ack_busy_q   <= 1'b1;
            push_bytes_q <= {program_bank, program_counter, status_now}; // see RULE14
          end else if (rti_go) begin
            state_q     <= ST_RTI;
            ack_busy_q  <= 1'b1;
            stack_pop_q <= 1'b1;
          end
        end
        ST_ACK: begin
          seq_cnt_q <= seq_cnt_q + 5'd1;
          if (seq_cnt_q < {2'b00, `IPR_ACK_PUSHES}) begin
            stack_push_q    <= 1'b1;                          // see RULE14
            stack_wr_data_q <= push_bytes_q[39:32];
            push_bytes_q    <= {push_bytes_q[31:0], 8'h00};
          end
          if (ack_end) begin
            state_q       <= ST_IDLE;                         // see RULE21
            ack_busy_q    <= 1'b0;
            vector_load_q <= 1'b1;                            // see RULE16
            vector_idx_q  <= acc_src_q;
            bank_out_q    <= `IPR_PG_VECTOR;
          end
        end
        ST_RTI: begin
          // Pops come back low status byte first, bank last
          seq_cnt_q   <= seq_cnt_q + 5'd1;
          pop_bytes_q <= {stack_rd_data, pop_bytes_q[39:8]};  // see RULE20
          if (rti_end) begin
            state_q         <= ST_IDLE;
            ack_busy_q      <= 1'b0;
            restore_valid_q <= 1'b1;
            bank_out_q      <= stack_rd_data;
            restore_pc_q    <= pop_bytes_q[39:24];
            restore_ps_q    <= pop_bytes_q[23:8];
          end else begin
            stack_pop_q <= 1'b1;
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          ack_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Status flags, mode register and APB slave
  always @(posedge clk) begin
    if (reset) begin
      iflag_q                  <= 1'b1;                       // see RULE24
      cpu_priority_threshold_q <= `IPR_THR_RESET;             // see RULE17
      pmr_q                    <= `IPR_PMR_RESET;             // see RULE11
      pready_q                 <= 1'b0;
      pslverr_q                <= 1'b0;
      prdata_q                 <= 32'h0000_0000;
    end else begin
      if (ack_mark) begin
        iflag_q <= 1'b1;                                      // see RULE15
        if (acc_src_q == `IPR_SRC_WATCHDOG)
          cpu_priority_threshold_q <= `IPR_THR_WATCHDOG;      // see RULE17
        else if (acc_src_q < `IPR_SRC_WATCHDOG)
          cpu_priority_threshold_q <= acc_lvl_q;              // see RULE15
      end else if (rti_end) begin
        iflag_q                  <= pop_bytes_q[8 + `IPR_PS_IFLAG_BIT]; // see RULE20
        cpu_priority_threshold_q <= pop_bytes_q[18:16];
      end else if (acc_wr && hit_ps) begin
        iflag_q                  <= pwdata[`IPR_PS_IFLAG_BIT];
        cpu_priority_threshold_q <= pwdata[`IPR_PS_THR_MSB:`IPR_PS_THR_LSB];
      end
      if (acc_wr && hit_pmr)
        pmr_q <= pwdata[7:0];
      // Zero-wait answer: ready rises in the cycle after setup
      pready_q  <= setup;
      pslverr_q <= setup && !(hit_ctrl || hit_ps || hit_pmr || hit_win);
      if (setup) begin
        if (hit_ctrl)
          prdata_q <= {28'h0, req_q[ctrl_src], level_q[ctrl_src]};
        else if (hit_ps)
          prdata_q <= {16'h0000, status_now};
        else if (hit_pmr)
          prdata_q <= {24'h000000, pmr_q};
        else if (hit_win)
          prdata_q <= {16'h0000, 3'h0, state_q, det_busy_q, acc_pend_q, 1'b0, acc_lvl_q, acc_src_q};
        else
          prdata_q <= 32'h0000_0000;
      end
    end
  end

endmodule // ipr_resolver

/* test/ipr_resolver_props.sv */
// Purpose: Port assertions for the interrupt priority resolver
// Assumes: One clock, reset synchronous and active high
// Notes:   Bound to the resolver at the foot of this file
`timescale 1ns/1ps
module ipr_resolver_props (
  input logic       clk,                     // Clock
  input logic       reset,                   // Reset
  input logic       psel,                    // Select
  input logic       penable,                 // Access
  input logic       pready_q,                // Ready
  input logic       pslverr_q,               // Error
  input logic       instr_done,              // Instr end
  input logic       stack_push_q,            // Push
  input logic       stack_pop_q,             // Pop
  input logic       vector_load_q,           // Vector
  input logic [4:0] vector_idx_q,            // Vector src
  input logic [7:0] bank_out_q,              // Bank
  input logic       restore_valid_q,         // Restored
  input logic       win_valid_q,             // Winner
  input logic [4:0] win_idx_q,               // Winner src
  input logic       iflag_q,                 // Disable flag
  input logic [2:0] cpu_priority_threshold_q // Threshold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst_state;
    disable iff (1'b0) reset |=> iflag_q && cpu_priority_threshold_q == 3'h0;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
  property p_apb_ready;
    psel && !penable |=> pready_q;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("ready late");
  property p_ready_one;
    pready_q |=> !pready_q;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready too long");
  property p_err_ready;
    pslverr_q |-> pready_q;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  // Five bytes back to back: bank, counter high, low, status high, low
  property p_push_run;
    $rose(stack_push_q) |-> stack_push_q [*5] ##1 !stack_push_q;
  endproperty
  a_push_run: assert property (p_push_run) else $error("push burst wrong");
  property p_ack_len;
    $rose(stack_push_q) |-> ##12 vector_load_q;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("vector load timing");
  property p_ack_after_done;
    $rose(stack_push_q) |-> $past(instr_done, 2);
  endproperty
  a_ack_after_done: assert property (p_ack_after_done) else $error("ack mid instruction");
  property p_vec_state;
    vector_load_q |-> bank_out_q == 8'h00 && iflag_q;
  endproperty
  a_vec_state: assert property (p_vec_state) else $error("vector state wrong");
  property p_pop_run;
    $rose(stack_pop_q) |-> stack_pop_q [*5] ##1 restore_valid_q;
  endproperty
  a_pop_run: assert property (p_pop_run) else $error("return pops wrong");
  property p_win_mask;
    win_valid_q && win_idx_q < 5'd16 |-> !$past(iflag_q) && $past(cpu_priority_threshold_q) != 3'h7;
  endproperty
  a_win_mask: assert property (p_win_mask) else $error("masked source taken");
  property p_wdt_thr;
    vector_load_q && vector_idx_q == 5'd16 |-> cpu_priority_threshold_q == 3'h7;
  endproperty
  a_wdt_thr: assert property (p_wdt_thr) else $error("watchdog threshold");
  c_vec: cover property (vector_load_q);
  c_ret: cover property (restore_valid_q);
  c_err: cover property (pslverr_q);
  c_brk: cover property (win_valid_q && win_idx_q == 5'd17);
endmodule // ipr_resolver_props

bind ipr_resolver ipr_resolver_props u_props (.clk, .reset, .psel, .penable, .pready_q, .pslverr_q, .instr_done,
  .stack_push_q, .stack_pop_q, .vector_load_q, .vector_idx_q, .bank_out_q, .restore_valid_q, .win_valid_q,
  .win_idx_q, .iflag_q, .cpu_priority_threshold_q);

/* test/ipr_core_stack.sv */
// Purpose: Core stack model facing the resolver
// Assumes: Pop data is needed in the same cycle as the pop strobe
// Notes:   Idle read data is the inverse of the last byte, so stale data is caught
`timescale 1ns/1ps
module ipr_core_stack (
  input  logic        clk,     // Clock
  input  logic        reset,   // Reset
  input  logic        push,    // Push strobe
  input  logic [7:0]  wr_data, // Byte pushed
  input  logic        pop,     // Pop strobe
  output logic [7:0]  rd_data, // Byte popped
  output logic [39:0] pushed   // Bytes 0 to 4, oldest high
);
  logic [7:0] mem_q [8];
  logic [2:0] sp_q;
  logic [7:0] last_q;
  assign rd_data = pop ? mem_q[sp_q - 3'd1] : ~last_q;
  assign pushed = {mem_q[0], mem_q[1], mem_q[2], mem_q[3], mem_q[4]};
  always @(posedge clk) begin
    if (reset) begin
      sp_q <= 3'd0;
      last_q <= 8'h00;
    end else if (push) begin
      mem_q[sp_q] <= wr_data;
      sp_q <= sp_q + 3'd1;
    end else if (pop) begin
      last_q <= rd_data;
      sp_q <= sp_q - 3'd1;
    end
  end
endmodule // ipr_core_stack

/* test/test_interrupt_priority_resolver.sv */
// Purpose: Self-checking bench for the interrupt priority resolver
// Assumes: 20 MHz clock, APB register access, stack held by the partner model
// Notes:   Source ctrl registers sit at four times their index
`timescale 1ns/1ps
`include "ipr_defines.vh"
module test_interrupt_priority_resolver;
  localparam logic [7:0] CIDX [16] = '{8'h7d, 8'h7e, 8'h7f, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
                                       8'h7a, 8'h7b, 8'h7c, 8'h72, 8'h71, 8'h74, 8'h73, 8'h70};
  localparam int         DET [4]   = '{7, 4, 2, 2};
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        wdt_event = 1'b0, brk_trap_instr = 1'b0, opcode_fetch = 1'b0, instr_done = 1'b0;
  logic        return_from_irq_instr = 1'b0;
  logic        pready_q, pslverr_q, stack_push_q, stack_pop_q, ack_busy_q, rerr;
  logic        win_valid_q, vector_load_q, restore_valid_q, iflag_q;
  logic [2:0]  cpu_priority_threshold_q;
  logic [4:0]  win_idx_q, vector_idx_q;
  logic [7:0]  stack_rd_data, stack_wr_data_q, bank_out_q;
  logic [11:0] paddr = 12'h000;
  logic [15:0] src_event = 16'h0000;
  logic [15:0] restore_pc_q, restore_ps_q;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, rdata;
  logic [39:0] pushed;
  int          n_fail, comparisons, cycles, n;

  always #25 clk = ~clk;

  ipr_resolver #(.NSRC(16)) u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .src_event, .wdt_event, .brk_trap_instr, .div_zero_trap(1'b0), .opcode_fetch,
    .instr_done, .return_from_irq_instr, .program_bank(8'h5a), .program_counter(16'h1234),
    .status_other(16'h00c3), .stack_rd_data, .stack_push_q, .stack_wr_data_q, .stack_pop_q, .ack_busy_q,
    .win_valid_q, .win_idx_q, .vector_load_q, .vector_idx_q, .bank_out_q, .restore_valid_q, .restore_pc_q,
    .restore_ps_q, .iflag_q, .cpu_priority_threshold_q);
  ipr_core_stack u_stack (.clk, .reset, .push(stack_push_q), .wr_data(stack_wr_data_q), .pop(stack_pop_q),
    .rd_data(stack_rd_data), .pushed);

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready_q !== 1'b1);
    rdata = prdata_q;
    rerr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask

  function logic [11:0] ca(input int i);
    return {2'b00, CIDX[i], 2'b00};
  endfunction

  task fetch(input int hold, output int cnt);
    @(posedge clk);
    opcode_fetch <= 1'b1;
    cnt = 0;
    repeat (hold) begin
      @(posedge clk);
      cnt++;
    end
    opcode_fetch <= 1'b0;
    while (win_valid_q !== 1'b1 && cnt < 20) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task serve(input logic [4:0] idx, input logic [2:0] thr, input logic [15:0] ps);
    chk("win_idx", idx, win_idx_q);
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    while (vector_load_q !== 1'b1) @(posedge clk);
    chk("pushed", {16'h5a12, 8'h34, ps}, pushed);
    chk("vector_idx", idx, vector_idx_q);
    chk("bank", 8'h00, bank_out_q);
    chk("iflag", 1'b1, iflag_q);
    chk("threshold", thr, cpu_priority_threshold_q);
    @(posedge clk);
    return_from_irq_instr <= 1'b1;
    @(posedge clk);
    return_from_irq_instr <= 1'b0;
    while (restore_valid_q !== 1'b1) @(posedge clk);
    chk("restore_pc", 16'h1234, restore_pc_q);
    chk("restore_ps", ps, restore_ps_q);
    chk("restore_bank", 8'h5a, bank_out_q);
  endtask

  task t_regs;
    chk("iflag", 1'b1, iflag_q);
    rd_chk("ps", `IPR_PS_ADDR, 32'h00c7);
    rd_chk("pmr", `IPR_PMR_ADDR, 32'h0);
    apb(1'b1, ca(3), 32'hd);
    rd_chk("ctrl", ca(3), 32'hd);
    apb(1'b1, ca(3), 32'h0);
    rd_chk("ctrl_clr", ca(3), 32'h0);
    rd_chk("unmapped", 12'h300, 32'h0);
    chk("unmapped_err", 1'b1, rerr);
    $display("test regs done");
  endtask

  task t_mask;
    apb(1'b1, `IPR_PS_ADDR, 32'h500);
    apb(1'b1, ca(8), 32'h5);
    @(posedge clk);
    src_event <= 16'h0100;
    @(posedge clk);
    src_event <= 16'h0000;
    fetch(1, n);
    chk("equal_level", 20, n);
    apb(1'b1, ca(8), 32'he);
    fetch(1, n);
    serve(5'd8, 3'h6, 16'h05c3);
    apb(1'b1, `IPR_PS_ADDR, 32'h004);
    apb(1'b1, ca(8), 32'hf);
    fetch(1, n);
    chk("iflag_block", 20, n);
    apb(1'b1, `IPR_PS_ADDR, 32'h700);
    fetch(1, n);
    chk("thr7_block", 20, n);
    apb(1'b1, ca(8), 32'h0);
    $display("test mask done");
  endtask

  // Opcode fetch held two cycles: the second sample lands mid-detection and must not restart it
  task t_detect;
    apb(1'b1, `IPR_PS_ADDR, 32'h704);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `IPR_PMR_ADDR, 32'(s * 16));
      @(posedge clk);
      wdt_event <= 1'b1;
      @(posedge clk);
      wdt_event <= 1'b0;
      fetch(2, n);
      chk("detect_time", DET[s] + 1, n);
      serve(5'd16, 3'h7, 16'h07c7);
    end
    apb(1'b1, `IPR_PS_ADDR, 32'h304);
    @(posedge clk);
    brk_trap_instr <= 1'b1;
    @(posedge clk);
    brk_trap_instr <= 1'b0;
    fetch(1, n);
    serve(5'd17, 3'h3, 16'h03c7);
    $display("test detect done");
  endtask

  task t_arb;
    apb(1'b1, `IPR_PS_ADDR, 32'h0);
    apb(1'b1, ca(3), 32'h4);
    apb(1'b1, ca(5), 32'h4);
    apb(1'b1, ca(6), 32'h7);
    apb(1'b1, ca(7), 32'h2);
    @(posedge clk);
    src_event <= 16'h80a8;
    @(posedge clk);
    src_event <= 16'h0000;
    rd_chk("req_set", ca(7), 32'ha);
    fetch(1, n);
    serve(5'd5, 3'h4, 16'h00c3);
    rd_chk("req_won", ca(5), 32'h4);
    rd_chk("req_lost", ca(3), 32'hc);
    apb(1'b1, ca(3), 32'h0);
    $display("test arbitrate done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_mask;
    t_detect;
    t_arb;
    tally_and_finish;
  end
endmodule // test_interrupt_priority_resolver
